// file: pkg/lomx_pkg.sv
// line output mix control: register indices, field positions, reset values
// assumes a single 100 MHz clock and an AXI4-Lite master on the register side
//
// Contract
// - each output level register holds a 4-bit level code, 1 dB steps, resets 0000.
// - bit 3 is the mute control; 0 mutes, 1 unmutes, resets to 0.
// - bit 1 reads 1 while gains are pending, 0 once applied; resets 1.
// - bit 0 reads 1 only when the line output is fully powered up; resets 0.
// - bit 7 of each path register is the routing enable, resets 0.
// - bits 6 to 0 of each path register hold the volume code, reset zero.
// - right line output has four independent source paths, each enable plus volume.
package lomx_pkg;

   // *****************************************************************
   // register indices; byte address is four times the index
   // *****************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;
   localparam int NUM_PATHS = 4;
   localparam int VOL_W = 7;
   localparam int LVL_W = 4;

   localparam logic [IDX_W-1:0] IDX_LEFT_LINE_OUT_LEVEL = 10'h056;
   localparam logic [IDX_W-1:0] IDX_RESERVED_BANK_A = 10'h057;
   localparam logic [IDX_W-1:0] IDX_LEFT_GAIN_TO_RIGHT_VOL = 10'h058;
   localparam logic [IDX_W-1:0] IDX_LEFT_PLAY_TO_RIGHT_VOL = 10'h059;
   localparam logic [IDX_W-1:0] IDX_RESERVED_BANK_B = 10'h05A;
   localparam logic [IDX_W-1:0] IDX_RIGHT_GAIN_TO_RIGHT_VOL = 10'h05B;
   localparam logic [IDX_W-1:0] IDX_RIGHT_PLAY_TO_RIGHT_VOL = 10'h05C;
   localparam logic [IDX_W-1:0] IDX_RIGHT_LINE_OUT_LEVEL = 10'h05D;

   // path order: left gain stage, left playback, right gain stage, right playback
   localparam logic [IDX_W-1:0] PATH_IDX [NUM_PATHS] = '{
      IDX_LEFT_GAIN_TO_RIGHT_VOL,
      IDX_LEFT_PLAY_TO_RIGHT_VOL,
      IDX_RIGHT_GAIN_TO_RIGHT_VOL,
      IDX_RIGHT_PLAY_TO_RIGHT_VOL
   };

   // *****************************************************************
   // field positions
   // *****************************************************************
   localparam int LVL_MSB = 7;
   localparam int LVL_LSB = 4;
   localparam int MUTE_BIT = 3;
   localparam int RSVD_BIT = 2;
   localparam int PEND_BIT = 1;
   localparam int PWR_BIT = 0;
   localparam int ROUTE_BIT = 7;
   localparam int VOL_MSB = 6;
   localparam int VOL_LSB = 0;

   // *****************************************************************
   // reset values
   // *****************************************************************
   localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
   localparam logic UNMUTE_RST = 1'b0;
   localparam logic PEND_RST = 1'b1;
   localparam logic PWR_RST = 1'b0;
   localparam logic ROUTE_RST = 1'b0;
   localparam logic [VOL_W-1:0] VOL_RST = 7'h00;
   localparam logic [7:0] RSVD_REG_VAL = 8'h00;

   // *****************************************************************
   // bus responses
   // *****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// file: pkg/lomx_stat_if.sv
// status carried from the pin synchroniser to the register bank
// assumes both ends run on sys_clk
`timescale 1ns/1ns
interface lomx_stat_if;
   logic [1:0] gain_pending;
   logic [1:0] powered_up;
   modport src (output gain_pending, output powered_up);
   modport dst (input gain_pending, input powered_up);
endinterface

// file: hw/lomx_sync.sv
// three-stage synchroniser for the analog status pins, one lane per bit
// assumes pins are asynchronous levels; output moves when stages two and three agree
`timescale 1ns/1ns
module lomx_sync
   import lomx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [1:0] gain_pending_in,
   input wire logic [1:0] powered_up_in,
   lomx_stat_if.src stat
);
   // *****************************************************************
   // per-bit lanes; index 0..1 pending, 2..3 power
   // *****************************************************************
   logic [3:0] raw;
   logic [3:0] s1_r, s2_r, s3_r, out_r;
   logic [3:0] s1_nxt, s2_nxt, s3_nxt, out_nxt;
   localparam logic [3:0] LANE_RST = {PWR_RST, PWR_RST, PEND_RST, PEND_RST};

   assign raw = {powered_up_in, gain_pending_in};

   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_lane
         always_comb
         begin
            s1_nxt[i] = raw[i];
            s2_nxt[i] = s1_r[i];
            s3_nxt[i] = s2_r[i];
            // single-cycle glitches at stage two never reach the output
            out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
         end
         always_ff @(posedge sys_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               s1_r[i] <= LANE_RST[i];
               s2_r[i] <= LANE_RST[i];
               s3_r[i] <= LANE_RST[i];
               out_r[i] <= LANE_RST[i];
            end
            else
            begin
               s1_r[i] <= s1_nxt[i];
               s2_r[i] <= s2_nxt[i];
               s3_r[i] <= s3_nxt[i];
               out_r[i] <= out_nxt[i];
            end
         end
      end
   endgenerate

   assign stat.gain_pending = out_r[1:0];
   assign stat.powered_up = out_r[3:2];
endmodule

// file: hw/lomx_path_reg.sv
// one source-to-line-output register: routing enable and volume code
// assumes a one-cycle write strobe with the byte already selected
`timescale 1ns/1ns
module lomx_path_reg
   import lomx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [7:0] wr_byte,
   output logic route_en,
   output logic [VOL_W-1:0] vol
);
   logic route_r, route_nxt;
   logic [VOL_W-1:0] vol_r, vol_nxt;

   always_comb
   begin
      route_nxt = route_r;
      vol_nxt = vol_r;
      if (wr_en)
      begin
         route_nxt = wr_byte[ROUTE_BIT];
         vol_nxt = wr_byte[VOL_MSB:VOL_LSB];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         route_r <= ROUTE_RST;
         vol_r <= VOL_RST;
      end
      else
      begin
         route_r <= route_nxt;
         vol_r <= vol_nxt;
      end
   end

   assign route_en = route_r;
   assign vol = vol_r;
endmodule

// file: hw/lomx_regs.sv
// line output mix control register bank with an AXI4-Lite slave
// assumes one master, one write and one read outstanding at most
`timescale 1ns/1ns
module lomx_regs
   import lomx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [lomx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [lomx_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lomx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [lomx_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] gain_pending_in,
   input wire logic [1:0] powered_up_in,
   output logic [lomx_pkg::LVL_W-1:0] left_line_out_level,
   output logic left_line_out_unmute,
   output logic [lomx_pkg::LVL_W-1:0] right_line_out_level,
   output logic right_line_out_unmute,
   output logic [lomx_pkg::NUM_PATHS-1:0] right_line_out_route_en,
   output logic [lomx_pkg::NUM_PATHS-1:0][lomx_pkg::VOL_W-1:0] right_line_out_vol
);
   import lomx_pkg::*;

   // *****************************************************************
   // status from the analog side
   // *****************************************************************
   lomx_stat_if stat ();

   lomx_sync u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .gain_pending_in(gain_pending_in),
      .powered_up_in(powered_up_in),
      .stat(stat.src)
   );

   // *****************************************************************
   // write channel state
   // *****************************************************************
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [IDX_W-1:0] wr_idx_r, wr_idx_nxt;
   logic [7:0] wr_byte_r, wr_byte_nxt;
   logic wr_lane_r, wr_lane_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic commit;
   logic wr_hit;

   // protection bits carry no meaning for this bank
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

   function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
      begin
         idx_mapped = (idx >= IDX_LEFT_LINE_OUT_LEVEL) && (idx <= IDX_RIGHT_LINE_OUT_LEVEL);
      end
   endfunction

   // both halves held: the write lands on the same edge that raises the response
   assign commit = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit = commit && wr_lane_r && idx_mapped(wr_idx_r);

   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      wr_idx_nxt = wr_idx_r;
      wr_byte_nxt = wr_byte_r;
      wr_lane_nxt = wr_lane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         wr_idx_nxt = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         wr_byte_nxt = s_axi_wdata[7:0];
         wr_lane_nxt = s_axi_wstrb[0];
      end
      if (commit)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = idx_mapped(wr_idx_r) ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
      end
      // no new address or data until the previous response is gone
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         wr_idx_r <= '0;
         wr_byte_r <= 8'h00;
         wr_lane_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         wr_idx_r <= wr_idx_nxt;
         wr_byte_r <= wr_byte_nxt;
         wr_lane_r <= wr_lane_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // *****************************************************************
   // output level and mute registers
   // *****************************************************************
   logic [1:0][LVL_W-1:0] level_r, level_nxt;
   logic [1:0] unmute_r, unmute_nxt;
   logic [1:0] lvl_wr;

   assign lvl_wr[0] = wr_hit && (wr_idx_r == IDX_LEFT_LINE_OUT_LEVEL);
   assign lvl_wr[1] = wr_hit && (wr_idx_r == IDX_RIGHT_LINE_OUT_LEVEL);

   always_comb
   begin
      level_nxt = level_r;
      unmute_nxt = unmute_r;
      for (int k = 0; k < 2; k++)
      begin
         if (lvl_wr[k])
         begin
            // codes above nine are stored as written; software keeps them out
            level_nxt[k] = wr_byte_r[LVL_MSB:LVL_LSB];
            unmute_nxt[k] = wr_byte_r[MUTE_BIT];
            // bits 2..0 are status or reserved and are not stored
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         level_r <= {LVL_RST, LVL_RST};
         unmute_r <= {UNMUTE_RST, UNMUTE_RST};
      end
      else
      begin
         level_r <= level_nxt;
         unmute_r <= unmute_nxt;
      end
   end

   assign left_line_out_level = level_r[0];
   assign left_line_out_unmute = unmute_r[0];
   assign right_line_out_level = level_r[1];
   assign right_line_out_unmute = unmute_r[1];

   // *****************************************************************
   // right line output source paths
   // *****************************************************************
   logic [NUM_PATHS-1:0] path_route;
   logic [NUM_PATHS-1:0][VOL_W-1:0] path_vol;

   genvar p;
   generate
      for (p = 0; p < NUM_PATHS; p++)
      begin : g_path
         lomx_path_reg u_path (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .wr_en(wr_hit && (wr_idx_r == PATH_IDX[p])),
            .wr_byte(wr_byte_r),
            .route_en(path_route[p]),
            .vol(path_vol[p])
         );
      end
   endgenerate

   assign right_line_out_route_en = path_route;
   assign right_line_out_vol = path_vol;

   // *****************************************************************
   // read channel
   // *****************************************************************
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [IDX_W-1:0] rd_idx;
   logic [7:0] rd_byte;

   assign rd_idx = s_axi_araddr[ADDR_W-1:2];

   function automatic logic [7:0] level_byte(input logic [LVL_W-1:0] lvl, input logic unm,
                                             input logic pend, input logic pwr);
      logic [7:0] b;
      begin
         b = 8'h00;
         b[LVL_MSB:LVL_LSB] = lvl;
         b[MUTE_BIT] = unm;
         b[RSVD_BIT] = 1'b0;
         b[PEND_BIT] = pend;
         b[PWR_BIT] = pwr;
         level_byte = b;
      end
   endfunction

   always_comb
   begin
      rd_byte = 8'h00;
      for (int k = 0; k < NUM_PATHS; k++)
      begin
         if (rd_idx == PATH_IDX[k])
         begin
            rd_byte = {path_route[k], path_vol[k]};
         end
      end
      if (rd_idx == IDX_LEFT_LINE_OUT_LEVEL)
      begin
         rd_byte = level_byte(level_r[0], unmute_r[0], stat.gain_pending[0], stat.powered_up[0]);
      end
      if (rd_idx == IDX_RIGHT_LINE_OUT_LEVEL)
      begin
         rd_byte = level_byte(level_r[1], unmute_r[1], stat.gain_pending[1], stat.powered_up[1]);
      end
      // reserved registers keep nothing a write could change
      if ((rd_idx == IDX_RESERVED_BANK_A) || (rd_idx == IDX_RESERVED_BANK_B))
      begin
         rd_byte = RSVD_REG_VAL;
      end
   end

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt = {24'h000000, rd_byte};
         rresp_nxt = idx_mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // *****************************************************************
   // bus outputs
   // *****************************************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
endmodule

// file: verif/lomx_regs_asserts.sv
// concurrent checks on the line output mix register bank
// assumes binding to lomx_regs; sees only its ports, one clock domain
`timescale 1ns/1ns
module lomx_regs_chk
   import lomx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [lomx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [lomx_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [lomx_pkg::LVL_W-1:0] left_line_out_level,
   input wire logic left_line_out_unmute,
   input wire logic [lomx_pkg::LVL_W-1:0] right_line_out_level,
   input wire logic right_line_out_unmute,
   input wire logic [lomx_pkg::NUM_PATHS-1:0] right_line_out_route_en,
   input wire logic [lomx_pkg::NUM_PATHS-1:0][lomx_pkg::VOL_W-1:0] right_line_out_vol
);
   // *****************************
   // index of the read under way
   // *****************************
   logic [IDX_W-1:0] rd_idx_r;
   logic [IDX_W-1:0] rd_idx_nxt;
   logic is_map;
   always_comb rd_idx_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr[11:2] : rd_idx_r;
   always_ff @(posedge sys_clk or negedge nrst) if (!nrst) rd_idx_r <= '0; else rd_idx_r <= rd_idx_nxt;
   assign is_map = (rd_idx_r >= IDX_LEFT_LINE_OUT_LEVEL) && (rd_idx_r <= IDX_RIGHT_LINE_OUT_LEVEL);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // *****************************
   // properties
   // *****************************
   property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
   property p_rsvd_bit; s_axi_rvalid && (rd_idx_r == IDX_LEFT_LINE_OUT_LEVEL || rd_idx_r == IDX_RIGHT_LINE_OUT_LEVEL)
      |-> s_axi_rdata[RSVD_BIT] == 1'b0; endproperty
   a_rsvd_bit: assert property (p_rsvd_bit) else $error("level bit 2 not zero");
   property p_lvl_l; s_axi_rvalid && rd_idx_r == IDX_LEFT_LINE_OUT_LEVEL
      |-> s_axi_rdata[7:3] == {left_line_out_level, left_line_out_unmute}; endproperty
   a_lvl_l: assert property (p_lvl_l) else $error("left level readback differs");
   property p_lvl_r; s_axi_rvalid && rd_idx_r == IDX_RIGHT_LINE_OUT_LEVEL
      |-> s_axi_rdata[7:3] == {right_line_out_level, right_line_out_unmute}; endproperty
   a_lvl_r: assert property (p_lvl_r) else $error("right level readback differs");
   property p_path; s_axi_rvalid && rd_idx_r == IDX_LEFT_GAIN_TO_RIGHT_VOL
      |-> s_axi_rdata[7:0] == {right_line_out_route_en[0], right_line_out_vol[0]}; endproperty
   a_path: assert property (p_path) else $error("path readback differs");
   property p_rsvd_reg; s_axi_rvalid && (rd_idx_r == IDX_RESERVED_BANK_A || rd_idx_r == IDX_RESERVED_BANK_B)
      |-> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY; endproperty
   a_rsvd_reg: assert property (p_rsvd_reg) else $error("reserved register not zero");
   property p_resp; s_axi_rvalid |-> s_axi_rresp == (is_map ? RESP_OKAY : RESP_DECERR); endproperty
   a_resp: assert property (p_resp) else $error("read response code wrong");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_wr_only; !$rose(s_axi_bvalid) |-> $stable({left_line_out_level, left_line_out_unmute,
      right_line_out_level, right_line_out_unmute, right_line_out_route_en, right_line_out_vol}); endproperty
   a_wr_only: assert property (p_wr_only) else $error("control output moved without write");
   property p_b_time; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
   a_b_time: assert property (p_b_time) else $error("write response late");
endmodule
bind lomx_regs lomx_regs_chk u_lomx_regs_chk (.sys_clk, .nrst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .left_line_out_level, .left_line_out_unmute, .right_line_out_level,
   .right_line_out_unmute, .right_line_out_route_en, .right_line_out_vol);

// file: verif/tb.sv
// self-checking bench for the line output mix register bank
// assumes an AXI4-Lite master on sys_clk and status pins driven as steady levels
`timescale 1ns/1ns
module tb;
   import lomx_pkg::*;
   logic sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, left_line_out_unmute, right_line_out_unmute;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, gain_pending_in, powered_up_in;
   logic [LVL_W-1:0] left_line_out_level, right_line_out_level;
   logic [NUM_PATHS-1:0] right_line_out_route_en;
   logic [NUM_PATHS-1:0][VOL_W-1:0] right_line_out_vol;
   int err_total, check_count;
   lomx_regs u_lomx_regs (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .gain_pending_in, .powered_up_in, .left_line_out_level, .left_line_out_unmute,
      .right_line_out_level, .right_line_out_unmute, .right_line_out_route_en, .right_line_out_vol);
   // *****************************
   // bus and compare tasks
   // *****************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, exp);
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // *****************************
   // scenarios
   // *****************************
   task automatic t_reset;
      chk(32'({left_line_out_level, left_line_out_unmute, right_line_out_level, right_line_out_unmute}), 0);
      chk(32'({right_line_out_route_en, right_line_out_vol}), 0);
      for (int i = 0; i < 8; i++) rdchk(10'(IDX_LEFT_LINE_OUT_LEVEL + i), (i == 0 || i == 7) ? 32'h2 : 32'h0,
         RESP_OKAY);
      $display("reset values done");
   endtask
   task automatic t_status;
      logic [3:0] pins [2] = '{4'b1001, 4'b0011};
      for (int k = 0; k < 2; k++)
      begin
         gain_pending_in <= pins[k][3:2];
         powered_up_in <= pins[k][1:0];
         repeat (8) @(posedge sys_clk);
         rdchk(IDX_LEFT_LINE_OUT_LEVEL, 32'({pins[k][2], pins[k][0]}), RESP_OKAY);
         rdchk(IDX_RIGHT_LINE_OUT_LEVEL, 32'({pins[k][3], pins[k][1]}), RESP_OKAY);
      end
      $display("status bits done");
   endtask
   task automatic t_levels;
      logic [1:0] r;
      logic [IDX_W-1:0] idx;
      for (int s = 0; s < 2; s++)
      begin
         idx = s ? IDX_RIGHT_LINE_OUT_LEVEL : IDX_LEFT_LINE_OUT_LEVEL;
         for (int c = 0; c < 10; c++)
         begin
            wr(idx, {4'(c), 4'hB}, 4'hF, r); // codes stay 0..9, status bits high, bit 2 left clear
            chk(32'(r), 32'(RESP_OKAY));
            rdchk(idx, 32'({4'(c), 4'b1001}), RESP_OKAY);
            chk(32'(s ? {right_line_out_level, right_line_out_unmute} : {left_line_out_level, left_line_out_unmute}),
               32'({4'(c), 1'b1}));
         end
         wr(idx, 8'h93, 4'hF, r);
         wr(idx, 8'h58, 4'h0, r); // strobe off, nothing stored
         rdchk(idx, 32'h91, RESP_OKAY);
      end
      chk(32'({left_line_out_unmute, right_line_out_unmute}), 0);
      $display("level and mute done");
   endtask
   task automatic t_paths;
      logic [7:0] pv [4] = '{8'h81, 8'h22, 8'hC5, 8'h7F};
      logic [1:0] r;
      for (int p = 0; p < 4; p++) wr(PATH_IDX[p], pv[p], 4'hF, r);
      for (int p = 0; p < 4; p++)
      begin
         rdchk(PATH_IDX[p], 32'(pv[p]), RESP_OKAY);
         chk(32'({right_line_out_route_en[p], right_line_out_vol[p]}), 32'(pv[p]));
      end
      $display("source paths done");
   endtask
   task automatic t_rsvd;
      logic [1:0] r;
      // reserved registers are only read, never written
      wr(IDX_RIGHT_LINE_OUT_LEVEL, 8'h93, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY));
      rdchk(IDX_RESERVED_BANK_A, 32'h0, RESP_OKAY);
      rdchk(IDX_RESERVED_BANK_B, 32'h0, RESP_OKAY);
      wr(10'h000, 8'hFF, 4'hF, r);
      chk(32'(r), 32'(RESP_DECERR));
      rdchk(10'h3FF, 32'h0, RESP_DECERR);
      $display("reserved and unmapped done");
   endtask
   // *****************************
   // clock, reset, sequence
   // *****************************
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #200000;
      err_total++; // hang cut short
      report_and_stop;
   end
   initial
   begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
      gain_pending_in = 2'b11;
      powered_up_in = 2'b00;
      err_total = 0;
      check_count = 0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_status;
      t_levels;
      t_paths;
      t_rsvd;
      report_and_stop;
   end
endmodule
